/* File: src/bthph_cfg.svh */
// constants for the bluetooth host power handshake block
`ifndef BTHPH_CFG_SVH
`define BTHPH_CFG_SVH
`define BTHPH_REF_SETTLE_NS   1000
`define BTHPH_CLK_NS          5
`define BTHPH_REF_SETTLE_CYC  ((`BTHPH_REF_SETTLE_NS + `BTHPH_CLK_NS - 1) / `BTHPH_CLK_NS)
`define BTHPH_IO_SETTLE_CYC   8
`define BTHPH_CNT_W           12
`define BTHPH_PADFUNC_RESET   2'h0
`define BTHPH_SLEEP_IDLE_CYC  16
`define BTHPH_OFF_CTRL        12'h000
`define BTHPH_OFF_STAT        12'h004
`define BTHPH_OFF_MASK        12'h008
`define BTHPH_OFF_RFPD        12'h00C
`define BTHPH_B_UART          0
`define BTHPH_B_DWPOL         1
`define BTHPH_B_HWPOL         2
`define BTHPH_B_EXTREF        3
`define BTHPH_B_HOSTATT       4
`define BTHPH_B_WLANCLK       5
`define BTHPH_B_SLEEPOK       6
`define BTHPH_B_AWAKE         0
`define BTHPH_B_RTSLOW        1
`define BTHPH_B_CLKREQ        2
`define BTHPH_B_READY         3
`endif

/* File: src/bthph_pkg.sv */
// state types for the device and host ends of the power handshake
package bthph_pkg;
    typedef enum logic [2:0] {
        BTHPH_OFF,
        BTHPH_REFWAIT,
        BTHPH_IOSETTLE,
        BTHPH_AWAKE,
        BTHPH_SLEEP
    } bthph_state_e;
    typedef enum logic [1:0] {
        BTHPH_H_IDLE,
        BTHPH_H_IOCFG,
        BTHPH_H_ENABLE
    } bthph_hstate_e;
endpackage

/* File: src/bthph_if.sv */
// pins between the radio device and the host processor
`timescale 1ns/1ps
interface bthph_if;
    logic devWakeRequestIn;   // host to device wake request
    logic hostAttentionOut;   // device to host wake
    logic radioEnableIn;      // host enable of the bluetooth core
    logic uartRequestToSendLow;  // device rts, active low
    logic uartClearToSendLow;    // host cts, active low
    logic clkReqOut;          // device reference clock request
    modport device (
        input  devWakeRequestIn,
        input  radioEnableIn,
        input  uartClearToSendLow,
        output hostAttentionOut,
        output uartRequestToSendLow,
        output clkReqOut
    );
    modport host (
        output devWakeRequestIn,
        output radioEnableIn,
        output uartClearToSendLow,
        input  hostAttentionOut,
        input  uartRequestToSendLow,
        input  clkReqOut
    );
endinterface

/* File: src/bthph_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
module bthph_sync
    import bthph_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic resetVal,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic stage1;   // metastability catcher, read only by stage two
    // two stages; reset value low, input inverted ahead of stage one while resetVal is high
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stage1  <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            stage1  <= asyncIn ^ resetVal;
            syncOut <= stage1;
        end
    end
endmodule

/* File: src/bthph_device.sv */
// device end: wake handshake, clock request, startup and rf power-down
`timescale 1ns/1ps
`include "bthph_cfg.svh"
// Contract
// RQ1: handshake pins used only in uart mode
// RQ2: wake asserted keeps or makes core awake
// RQ3: wake released allows sleep after criteria
// RQ4: host stays awake while attention asserted
// RQ5: host may sleep after attention drops
// RQ6: wake and attention polarity set by software
// RQ7: clock request high when bt or wlan needs
// RQ8: pad function selection reads zero
// RQ9: host configures pins, then raises enable
// RQ10: settle pins after reset and ref settling
// RQ11: rts low after cts low once ready
// RQ12: clock request raised after enable, external ref
// RQ13: separate tx rx pll pa power-downs
// RQ14: power actions from software or baseband packets
// RQ15: core held in reset while enable low
// RQ16: synchronise wake and cts inputs first
module bthph_device
    import bthph_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    bthph_if.device          pins,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        basebandPktActive,
    input  wire logic [3:0]  basebandPdReq,
    output logic      [3:0]  rfPowerDown,
    output logic      [1:0]  padFunction,
    output logic             irq
);
    // state, control and status storage
    bthph_state_e state;       // core power state
    bthph_state_e next_state;  // next core power state
    logic [7:0]  ctrl;         // software control bits
    logic [3:0]  stat;         // sticky event bits
    logic [3:0]  mask;         // interrupt mask
    logic [3:0]  swPd;         // software power-down request
    logic [`BTHPH_CNT_W-1:0] cnt;  // settle and idle counter
    logic        coreRstn;     // internal reset, enable and rstn
    logic        enSync;       // synchronised enable
    logic        wakeSync;     // synchronised wake, polarity applied
    logic        ctsSync;      // synchronised cts low level
    logic        hostAttOut;   // attention pin register
    logic        rtsLow;       // rts pin register
    logic        clkReq;       // clock request pin register
    // synchronisers for the asynchronous host pins; only their second
    // stage is read by the logic below
    // enable: active high, idle low
    bthph_sync uEn (.core_clk(core_clk), .rstn(rstn), .resetVal(1'b0),
        .asyncIn(pins.radioEnableIn), .syncOut(enSync)); // RQ16
    // wake: polarity is folded in ahead of the first stage, so the
    // synchronised level is active high in either setting
    bthph_sync uWake (.core_clk(core_clk), .rstn(rstn),
        .resetVal(~ctrl[`BTHPH_B_DWPOL]),
        .asyncIn(pins.devWakeRequestIn), .syncOut(wakeSync)); // RQ16 RQ6
    // cts: active low pin, synchronised level is high while asserted
    bthph_sync uCts (.core_clk(core_clk), .rstn(rstn), .resetVal(1'b1),
        .asyncIn(pins.uartClearToSendLow), .syncOut(ctsSync)); // RQ16
    // the core stays in reset until enable has passed both synchroniser stages,
    // so a glitch sampled high on one edge still lifts coreRstn for a cycle
    assign coreRstn = rstn & enSync; // RQ15
    // bus decode: an access is the second cycle of a transfer
    wire accessCyc = psel & penable;
    wire wrCyc     = accessCyc & pwrite;
    wire rdCyc     = accessCyc & ~pwrite;
    // one hit per register word; any other address is refused
    wire hitCtrl   = paddr == `BTHPH_OFF_CTRL;
    wire hitStat   = paddr == `BTHPH_OFF_STAT;
    wire hitMask   = paddr == `BTHPH_OFF_MASK;
    wire hitRfpd   = paddr == `BTHPH_OFF_RFPD;
    wire hitAny    = hitCtrl | hitStat | hitMask | hitRfpd;
    // control and state decode
    wire uartMode  = ctrl[`BTHPH_B_UART];
    // rts may answer only once the settling phases are over
    wire ready     = (state == BTHPH_AWAKE) | (state == BTHPH_SLEEP);
    wire awake     = state == BTHPH_AWAKE;
    // wake request counts only in uart mode
    wire wakeReq   = uartMode & wakeSync; // RQ1 RQ2
    // sleep needs software consent, no packet traffic and a quiet spell
    wire sleepOk   = ctrl[`BTHPH_B_SLEEPOK] & ~basebandPktActive &
                     (cnt == `BTHPH_CNT_W'(`BTHPH_SLEEP_IDLE_CYC));
    // one counter times both settling phases
    wire cntDone   = (state == BTHPH_REFWAIT) ?
                     (cnt == `BTHPH_CNT_W'(`BTHPH_REF_SETTLE_CYC)) :
                     (cnt == `BTHPH_CNT_W'(`BTHPH_IO_SETTLE_CYC));
    // attention is raised by software, and only in uart mode
    wire attLevel  = uartMode & ctrl[`BTHPH_B_HOSTATT]; // RQ1
    // events: rts asserted, clock request, woken, ready to sleep
    wire [3:0] evt = {awake & ctsSync & ready, clkReq,
                      ~awake & wakeReq, awake & ~wakeReq};
    // read data selection; unmapped words read zero
    wire [31:0] rdMux = hitCtrl ? {24'h000000, ctrl} :
                        hitStat ? {28'h0000000, stat} :
                        hitMask ? {28'h0000000, mask} :
                        hitRfpd ? {28'h0000000, swPd} :
                                  32'h00000000;
    // startup and sleep sequencing
    always_comb begin
        next_state = state;
        case (state)
            // leave power-on reset at once and time the reference
            BTHPH_OFF:      next_state = BTHPH_REFWAIT;
            // reference clock settling time
            BTHPH_REFWAIT:  if (cntDone) next_state = BTHPH_IOSETTLE; // RQ10
            // io pins settle to their defined levels
            BTHPH_IOSETTLE: if (cntDone) next_state = BTHPH_AWAKE; // RQ10
            // stay awake while the host wants us or sleep is refused
            BTHPH_AWAKE:    if (!wakeReq && sleepOk) begin
                next_state = BTHPH_SLEEP; // RQ3
            end
            // host wake request or packet handling brings the core back
            BTHPH_SLEEP:    if (wakeReq || basebandPktActive) begin
                next_state = BTHPH_AWAKE; // RQ2 RQ14
            end
            // unreachable codes fall back to the reset state
            default:        next_state = BTHPH_OFF;
        endcase
    end
    // state and counter, held in reset while enable is low
    // the counter restarts on a state change and on any activity, and
    // stops at full scale so that it cannot wrap into a false match
    always_ff @(posedge core_clk or negedge coreRstn) begin
        if (!coreRstn) begin
            state <= BTHPH_OFF; // RQ15
            cnt   <= '0;
        end else begin
            state <= next_state;
            if (next_state != state || wakeReq || basebandPktActive) begin
                cnt <= '0;
            end else if (cnt != {`BTHPH_CNT_W{1'b1}}) begin
                cnt <= cnt + 1'b1;
            end
        end
    end
    // pin registers
    always_ff @(posedge core_clk or negedge coreRstn) begin
        if (!coreRstn) begin
            // idle pins: attention low, rts deasserted, no clock request
            hostAttOut  <= 1'b0;
            rtsLow      <= 1'b1;
            clkReq      <= 1'b0;
            // every rf sub-block is powered down until the core is awake
            rfPowerDown <= 4'hF;
            padFunction <= `BTHPH_PADFUNC_RESET; // RQ8
        end else begin
            // attention level in the software chosen polarity
            hostAttOut  <= attLevel ~^ ctrl[`BTHPH_B_HWPOL]; // RQ6 RQ4 RQ5
            // rts low only while ready and the host holds cts asserted
            rtsLow      <= ~(ready & ctsSync); // RQ11
            // clock request for an external reference; in sleep it stays
            // up only while the wlan side still needs the clock
            clkReq      <= ctrl[`BTHPH_B_EXTREF] & (~(state == BTHPH_SLEEP)
                           | ctrl[`BTHPH_B_WLANCLK]); // RQ7 RQ12
            // software or baseband power-downs, everything off in sleep
            rfPowerDown <= awake ? (swPd | basebandPdReq) : 4'hF; // RQ13 RQ14
            // pad function select is fixed at zero
            padFunction <= `BTHPH_PADFUNC_RESET; // RQ8
        end
    end
    // software registers, cleared by rstn only so that settings survive
    // a low enable; sticky status with read-to-clear where set wins
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= 8'h00;
            mask <= 4'h0;
            swPd <= 4'h0;
            stat <= 4'h0;
            irq  <= 1'b0;
        end else begin
            // control, mask and software power-down words
            if (wrCyc && hitCtrl) ctrl <= pwdata[7:0]; // RQ6 RQ14
            if (wrCyc && hitMask) mask <= pwdata[3:0];
            if (wrCyc && hitRfpd) swPd <= pwdata[3:0]; // RQ13
            // a status read clears the word, but an event in the same
            // cycle still sets its bit
            stat <= ((rdCyc && hitStat) ? 4'h0 : stat) | evt;
            // level interrupt, one cycle behind the status
            irq  <= |(stat & mask);
        end
    end
    // apb answer in the access cycle, no wait states
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // ready rises in setup and stands through the access cycle
            pready  <= psel & ~penable;
            // refused when the address hits no register
            pslverr <= psel & ~penable & ~hitAny;
            // read data taken in setup so it stands in the access cycle
            prdata  <= rdMux;
        end
    end
    // pins come straight from their registers
    assign pins.hostAttentionOut     = hostAttOut;
    assign pins.uartRequestToSendLow = rtsLow;
    assign pins.clkReqOut            = clkReq;
endmodule

/* File: src/bthph_host.sv */
// host end: io configuration, enable, cts and wake request
`timescale 1ns/1ps
`include "bthph_cfg.svh"
module bthph_host
    import bthph_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rstn,
    bthph_if.host     pins,
    input  wire logic powerOnReq,
    input  wire logic wantDevice,
    input  wire logic uartRxReady,
    input  wire logic wakePolHigh,
    input  wire logic attPolHigh,
    output logic      hostMustStayAwake,
    output logic      txAllowed,
    output logic      refClkOn
);
    bthph_hstate_e hst;     // host startup state
    logic [`BTHPH_CNT_W-1:0] cnt;  // io configure delay
    logic att1, att2;       // attention synchroniser
    logic rts1, rts2;       // rts synchroniser
    logic clk1, clk2;       // clock request synchroniser
    logic enable, wake, cts;
    // pin configuration first, then enable
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hst    <= BTHPH_H_IDLE;
            cnt    <= '0;
            enable <= 1'b0;
        end else begin
            case (hst)
                BTHPH_H_IDLE:  if (powerOnReq) hst <= BTHPH_H_IOCFG;
                BTHPH_H_IOCFG: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == `BTHPH_CNT_W'(`BTHPH_IO_SETTLE_CYC)) begin
                        hst    <= BTHPH_H_ENABLE;
                        enable <= 1'b1; // RQ9
                    end
                end
                BTHPH_H_ENABLE: if (!powerOnReq) begin
                    hst    <= BTHPH_H_IDLE;
                    enable <= 1'b0;
                    cnt    <= '0;
                end
                default: hst <= BTHPH_H_IDLE;
            endcase
        end
    end
    // wake, cts and synchronised status
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wake <= 1'b0;
            cts  <= 1'b1;
            {att1, att2, rts1, rts2, clk1, clk2} <= 6'h00;
            hostMustStayAwake <= 1'b0;
            txAllowed <= 1'b0;
            refClkOn  <= 1'b0;
        end else begin
            wake <= ~(wantDevice & enable) ^ wakePolHigh; // RQ1
            cts  <= ~(enable & uartRxReady);
            att1 <= pins.hostAttentionOut;
            att2 <= att1;
            rts1 <= pins.uartRequestToSendLow;
            rts2 <= rts1;
            clk1 <= pins.clkReqOut;
            clk2 <= clk1;
            hostMustStayAwake <= enable & (att2 ~^ attPolHigh); // RQ4 RQ5
            txAllowed <= enable & ~rts2;
            refClkOn  <= enable & clk2;
        end
    end
    assign pins.devWakeRequestIn   = wake;
    assign pins.radioEnableIn      = enable;
    assign pins.uartClearToSendLow = cts;
endmodule

/* File: bench/bthph_props.sv */
// concurrent checks on the pins between device and host
`timescale 1ns/1ps
module bthph_props (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic devWakeRequestIn,
    input wire logic hostAttentionOut,
    input wire logic radioEnableIn,
    input wire logic uartRequestToSendLow,
    input wire logic uartClearToSendLow,
    input wire logic clkReqOut
);
    int unsigned enCnt;  // cycles that enable has been high, saturating
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // restart the count on every low enable so settling is timed from it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) enCnt <= 0;
        else if (!radioEnableIn) enCnt <= 0;
        else if (enCnt < 1000) enCnt <= enCnt + 1;
    end
    a_rts_held_off: assert property (!radioEnableIn [*6]
        |-> uartRequestToSendLow) else $error("rts low while disabled");
    a_clk_held_off: assert property (!radioEnableIn [*6]
        |-> !clkReqOut) else $error("clock request while disabled");
    a_att_held_off: assert property (!radioEnableIn [*6]
        |-> $stable(hostAttentionOut)) else $error("attention moved");
    a_rts_settle: assert property (radioEnableIn && enCnt < 200
        |-> uartRequestToSendLow) else $error("rts before settling");
    a_rts_cause: assert property ($fell(uartRequestToSendLow)
        |-> $past(!uartClearToSendLow, 2)) else $error("rts without cts");
    a_rts_answer: assert property (
        (enCnt > 216 && !uartClearToSendLow) [*4] |-> !uartRequestToSendLow)
        else $error("rts not answering cts");
    a_clk_cause: assert property ($rose(clkReqOut)
        |-> radioEnableIn && $past(radioEnableIn, 2))
        else $error("clock request before enable");
    a_cts_order: assert property ($fell(uartClearToSendLow)
        |-> radioEnableIn) else $error("cts before enable");
    c_rts: cover property ($fell(uartRequestToSendLow));
    c_clk: cover property ($rose(clkReqOut));
    c_att: cover property ($changed(hostAttentionOut));
endmodule

/* File: bench/tb_bt_host_power_handshake.sv */
// testbench joining the device and host ends across the pins
`timescale 1ns/1ps
`include "bthph_cfg.svh"
module tb_bt_host_power_handshake
    import bthph_pkg::*;
;
    logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        irq, pwrOn, want, rxRdy, wPol, aPol, err;
    logic        mustWake, txOk, refOn, bbPkt;
    logic [3:0]  bbPd, rfPd;
    logic [1:0]  padFn;
    int          bad_count, num_checks, n;
    bthph_if     pins ();
    bthph_device i_bthph_device (.core_clk(core_clk), .rstn(rstn),
        .pins(pins), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .basebandPktActive(bbPkt),
        .basebandPdReq(bbPd), .rfPowerDown(rfPd), .padFunction(padFn),
        .irq(irq));
    bthph_host i_bthph_host (.core_clk(core_clk), .rstn(rstn), .pins(pins),
        .powerOnReq(pwrOn), .wantDevice(want), .uartRxReady(rxRdy),
        .wakePolHigh(wPol), .attPolHigh(aPol), .hostMustStayAwake(mustWake),
        .txAllowed(txOk), .refClkOn(refOn));
    bthph_props i_bthph_props (.core_clk(core_clk), .rstn(rstn),
        .devWakeRequestIn(pins.devWakeRequestIn),
        .hostAttentionOut(pins.hostAttentionOut),
        .radioEnableIn(pins.radioEnableIn),
        .uartRequestToSendLow(pins.uartRequestToSendLow),
        .uartClearToSendLow(pins.uartClearToSendLow),
        .clkReqOut(pins.clkReqOut));
    // free running 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // verdict and end of run
    task automatic conclude();
        if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // compare one value, four-state exact
    task automatic chk(input logic [31:0] got, exp, input string m);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge core_clk);
    endtask
    // one apb transfer; read data and error land in rd and err
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            conclude();
        end
    endtask
    // power up through settling until rts answers cts
    task automatic t_start();
        pwrOn <= 1'b1;
        n = 0;
        while (pins.uartRequestToSendLow !== 1'b0 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        chk(n >= 9 + `BTHPH_REF_SETTLE_CYC + `BTHPH_IO_SETTLE_CYC
            && n < 400, 1, "startup time");
        if (n >= 400) conclude();
        apb(1, `BTHPH_OFF_CTRL, 32'h0000000F);
        // the host sees the request through two flops and one register
        tick(5);
        chk(pins.clkReqOut, 1, "clock request");
        chk(refOn, 1, "reference clock");
        chk(txOk, 1, "host transmit");
    endtask
    // attention in both polarities, and ignored outside uart mode
    task automatic t_att();
        for (int p = 0; p < 2; p++) begin
            aPol <= p[0];
            apb(1, `BTHPH_OFF_CTRL, 32'h1B | (p << 2));
            tick(6);
            chk(pins.hostAttentionOut, p, "attention level");
            chk(mustWake, 1, "host kept awake");
            apb(1, `BTHPH_OFF_CTRL, 32'h0B | (p << 2));
            tick(6);
            chk(pins.hostAttentionOut, !p, "attention idle");
            chk(mustWake, 0, "host free to sleep");
        end
        apb(1, `BTHPH_OFF_CTRL, 32'h0000001E);
        tick(6);
        chk(mustWake, 0, "attention outside uart");
    endtask
    // sleep, clock request for wlan, wake with interrupt
    task automatic t_sleep();
        apb(1, `BTHPH_OFF_MASK, 32'h00000002);
        apb(1, `BTHPH_OFF_CTRL, 32'h0000004F);
        want <= 1'b0;
        tick(40);
        chk(rfPd, 4'hF, "asleep");
        chk(pins.clkReqOut, 0, "no clock need");
        apb(1, `BTHPH_OFF_CTRL, 32'h0000006F);
        tick(4);
        chk(pins.clkReqOut, 1, "wlan clock need");
        // packet handling wakes the core without the host
        bbPkt <= 1'b1;
        tick(4);
        chk(rfPd, 4'h0, "packet wake");
        bbPkt <= 1'b0;
        tick(40);
        chk(rfPd, 4'hF, "asleep after packet");
        want <= 1'b1;
        tick(10);
        chk(irq, 1, "wake interrupt");
        apb(0, `BTHPH_OFF_STAT, 0);
        chk(rd[1], 1, "wake status");
        apb(0, `BTHPH_OFF_STAT, 0);
        chk(rd[1], 0, "status cleared");
        tick(2);
        chk(irq, 0, "interrupt cleared");
        apb(0, `BTHPH_OFF_CTRL, 0);
        chk(rd[7:0], 8'h6F, "control readback");
        // active low wake request on both ends
        wPol <= 1'b0;
        apb(1, `BTHPH_OFF_CTRL, 32'h0000004D);
        want <= 1'b0;
        tick(40);
        chk(rfPd, 4'hF, "asleep, wake active low");
        want <= 1'b1;
        tick(10);
        chk(rfPd, 4'h0, "awake, wake active low");
    endtask
    // separate rf power-downs from software and baseband
    task automatic t_rf();
        for (int i = 0; i < 4; i++) begin
            apb(1, `BTHPH_OFF_RFPD, 32'h1 << i);
            tick(3);
            chk(rfPd, 4'h1 << i, "software power-down");
        end
        apb(1, `BTHPH_OFF_RFPD, 0);
        bbPd <= 4'hA;
        tick(3);
        chk(rfPd, 4'hA, "baseband power-down");
        bbPd <= 4'h0;
        apb(0, 12'h010, 0);
        chk(err, 1, "unmapped address");
    endtask
    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, bbPkt, bbPd} = '0;
        {pwrOn, want, rxRdy, wPol, aPol} = 5'h0F;
        rstn = 1'b0;
        tick(5);
        rstn <= 1'b1;
        tick(1);
        chk(pins.uartRequestToSendLow, 1, "rts at reset");
        chk(pins.clkReqOut, 0, "clkreq at reset");
        chk(rfPd, 4'hF, "rf off at reset");
        chk(padFn, 0, "pad function");
        t_start();
        t_att();
        t_sleep();
        t_rf();
        pwrOn <= 1'b0;
        tick(20);
        chk(pins.uartRequestToSendLow, 1, "rts when off");
        chk(rfPd, 4'hF, "rf when off");
        conclude();
    end
endmodule
